// *** hdl/ead_agen.sv ***
// ead_agen: combinational effective-address adder for all memory modes
// assumes base already holds the address register or the program counter
`timescale 1ns/100ps
module ead_agen
	import ead_pkg::*;
(
	// latched request in, addresses out
	ead_agen_if.calc ag
);
	logic [31:0] idx_val;
	logic [31:0] scaled;
	logic [31:0] bd;
	logic [31:0] od;
	logic [31:0] sz;

	always_comb begin
		idx_val = ag.idx_long ? ag.idx : sext16(ag.idx[15:0]); // [RULE_12]
		scaled  = idx_val << ag.scale; // [RULE_12]
		bd = 32'h0;
		if (ag.bd_en)
			bd = ag.ext_long ? ag.ext : sext16(ag.ext[15:0]); // [RULE_13]
		od = 32'h0;
		if (ag.od_en)
			od = ag.od_long ? ag.od : sext16(ag.od[15:0]); // [RULE_14]
		sz = size_bytes(ag.size);
		ag.inner    = 32'h0;
		ag.ea       = 32'h0;
		ag.reg_next = ag.base;
		case (ag.mode)
		M_IND:     ag.ea = ag.base;
		M_POSTINC: begin
			ag.ea       = ag.base;
			ag.reg_next = ag.base + sz; // [RULE_17] [RULE_20]
		end
		M_PREDEC: begin
			ag.ea       = ag.base - sz; // [RULE_20]
			ag.reg_next = ag.base - sz; // [RULE_17]
		end
		M_DISP16, M_PC_DISP:
			ag.ea = ag.base + sext16(ag.ext[15:0]); // [RULE_11] [RULE_18]
		M_IDX8, M_PC_IDX8:
			ag.ea = ag.base + sext8(ag.ext[7:0]) + scaled; // [RULE_11] [RULE_18]
		M_IDXBD, M_PC_IDXBD:
			ag.ea = ag.base + bd + scaled; // [RULE_13] [RULE_18]
		M_MEM_PRE, M_PC_MEM_PRE: begin
			ag.inner = ag.base + bd + scaled; // [RULE_19]
			ag.ea    = ag.ptr + od; // [RULE_14] [RULE_15]
		end
		M_MEM_POST, M_PC_MEM_POST: begin
			ag.inner = ag.base + bd; // [RULE_19]
			ag.ea    = ag.ptr + scaled + od; // [RULE_14] [RULE_19]
		end
		M_ABS_W:   ag.ea = sext16(ag.ext[15:0]); // [RULE_21]
		M_ABS_L:   ag.ea = ag.ext; // [RULE_21]
		default:   ag.ea = 32'h0;
		endcase
	end
endmodule

// *** hdl/ead_fmt.sv ***
// ead_fmt: combinational operand format conversion
// assumes the caller registers the result; denormal reals flush to zero
`timescale 1ns/100ps
module ead_fmt
	import ead_pkg::*;
(
	// operation select
	input  wire ead_fop_t     op,
	input  wire ead_size_t    size,
	input  wire logic [4:0]   bf_off,
	input  wire logic [4:0]   bf_wid,
	input  wire logic         bf_signed,
	// data
	input  wire logic [95:0]  din,
	output logic      [95:0]  dout
);
	function automatic logic [79:0] int_to_ext(input logic [31:0] v);
		logic [31:0] mag;
		logic [5:0]  msb;
		logic [63:0] man;
		mag = v[31] ? 32'(-v) : v; // [RULE_09]
		msb = 6'h0;
		for (int i = 0; i < 32; i++)
			if (mag[i])
				msb = 6'(i);
		man = {mag, 32'h0} << (6'd31 - msb);
		int_to_ext = (mag == 32'h0) ? {v[31], 79'h0} :
			{v[31], X_BIAS + {9'h0, msb}, man};
	endfunction

	function automatic logic [31:0] bf_extract(input logic [63:0] d,
		input logic [4:0] off, input logic [4:0] wid, input logic sgn);
		logic [63:0] sh;
		logic [31:0] mask;
		logic [5:0]  w;
		sh   = d >> off;
		w    = (wid == 5'h0) ? 6'd32 : {1'b0, wid};
		mask = 32'(33'h1ffffffff >> (6'd33 - w));
		bf_extract = sh[31:0] & mask;
		if (sgn && sh[w - 6'd1])
			bf_extract = bf_extract | ~mask;
	endfunction

	logic [31:0] ival;
	logic [7:0]  se;
	logic [10:0] de;

	always_comb begin
		case (size)
		SZ_BYTE: ival = sext8(din[7:0]);
		SZ_WORD: ival = sext16(din[15:0]);
		default: ival = din[31:0];
		endcase
		se   = din[30:23];
		de   = din[62:52];
		dout = 96'h0;
		case (op)
		F_INT2X: dout[79:0] = int_to_ext(ival); // [RULE_10]
		F_SGL2X: begin
			if (se == S_EXP_MAX)
				dout[79:0] = {din[31], X_EXP_MAX, 1'b1, din[22:0], 40'h0};
			else if (se != 8'h0)
				dout[79:0] = {din[31], X_BIAS - S_BIAS + {7'h0, se},
					1'b1, din[S_MAN_W-1:0], 40'h0}; // [RULE_05]
			else
				dout[79] = din[31];
		end
		F_DBL2X: begin
			if (de == D_EXP_MAX)
				dout[79:0] = {din[63], X_EXP_MAX, 1'b1, din[51:0], 11'h0};
			else if (de != 11'h0)
				dout[79:0] = {din[63], X_BIAS - D_BIAS + {4'h0, de},
					1'b1, din[D_MAN_W-1:0], 11'h0}; // [RULE_06]
			else
				dout[79] = din[63];
		end
		// sign and exponent, pad word, then mantissa
		F_X2MEM: dout = {din[X_W-1:X_MAN_W], {X_PAD_W{1'b0}},
			din[X_MAN_W-1:0]}; // [RULE_07] [RULE_08]
		F_BCD_PACK: dout[15:0] = {din[27:24], din[19:16], din[11:8],
			din[3:0]}; // [RULE_02]
		F_BCD_UNPK: dout[31:0] = {4'h0, din[15:12], 4'h0, din[11:8],
			4'h0, din[7:4], 4'h0, din[3:0]}; // [RULE_02]
		F_BF_EXT: dout[31:0] = bf_extract(din[63:0], bf_off, bf_wid,
			bf_signed); // [RULE_01]
		default: dout = 96'h0;
		endcase
	end
endmodule

// *** hdl/ead_top.sv ***
// ead_top: effective-address generation, register file and format unit
// assumes decoder holds a request until REQ_READY and memory answers a
// pointer fetch with one MEM_RD_VALID pulse
//
// Behaviour
// RULE_01 - bit fields of 1 to 32 consecutive bits can be extracted
// RULE_02 - decimal digits convert between packed and unpacked byte layouts
// RULE_03 - a quad word is read from any two data registers
// RULE_04 - 16-byte block operands sit at addresses aligned to 16 bytes
// RULE_05 - single real: sign, 8-bit exponent, 23-bit mantissa
// RULE_06 - double real: sign, 11-bit exponent, 52-bit mantissa
// RULE_07 - extended real: sign, 15-bit exponent, 64-bit mantissa
// RULE_08 - extended real in memory takes 96 bits with 16 pad bits
// RULE_09 - byte, word and long integers are twos complement
// RULE_10 - integers entering float work become extended reals automatically
// RULE_11 - 8 and 16 bit displacements are sign extended and added
// RULE_12 - index is word or long, from any register, scaled 1/2/4/8
// RULE_13 - optional base displacement is 16 or 32 bits, sign extended
// RULE_14 - optional outer displacement is added after memory indirection
// RULE_15 - bracketed address fetches a long word used as pointer
// RULE_16 - immediates are 8, 16 or 32 bits wide
// RULE_17 - register indirect offers postinc, predec, displacement, index
// RULE_18 - program counter replaces the base register in relative modes
// RULE_19 - preindexed adds index before fetch, postindexed after it
// RULE_20 - postinc adds operand size after, predec subtracts before
// RULE_21 - absolute short is sign extended, absolute long used whole
`timescale 1ns/100ps
module ead_top
	import ead_pkg::*;
(
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	// address request
	input  wire logic        REQ_VALID,
	input  wire ead_mode_t   REQ_MODE,
	input  wire ead_size_t   REQ_SIZE,
	input  wire logic [2:0]  REQ_REG,
	input  wire logic [3:0]  REQ_IDX_SEL,
	input  wire logic        REQ_IDX_LONG,
	input  wire logic [1:0]  REQ_SCALE,
	input  wire logic [31:0] REQ_EXT,
	input  wire logic        REQ_EXT_LONG,
	input  wire logic        REQ_BD_EN,
	input  wire logic [31:0] REQ_OD,
	input  wire logic        REQ_OD_LONG,
	input  wire logic        REQ_OD_EN,
	input  wire logic [31:0] REQ_PC,
	output logic             REQ_READY,
	// address result
	output logic             EA_VALID,
	output logic [31:0]      EA_ADDR,
	output logic             EA_IS_REG,
	output logic             EA_IS_IMM,
	output logic [31:0]      EA_IMM,
	output logic             EA_ALIGN_ERR,
	// pointer fetch
	output logic             MEM_RD_REQ,
	output logic [31:0]      MEM_RD_ADDR,
	input  wire logic        MEM_RD_VALID,
	input  wire logic [31:0] MEM_RD_DATA,
	// register file
	input  wire logic        RF_WE,
	input  wire logic [3:0]  RF_SEL,
	input  wire logic [31:0] RF_WDATA,
	input  wire logic [2:0]  QUAD_HI_SEL,
	input  wire logic [2:0]  QUAD_LO_SEL,
	output logic [63:0]      QUAD_DATA,
	// format conversion
	input  wire logic        FMT_VALID,
	input  wire ead_fop_t    FMT_OP,
	input  wire ead_size_t   FMT_SIZE,
	input  wire logic [4:0]  FMT_BF_OFF,
	input  wire logic [4:0]  FMT_BF_WID,
	input  wire logic        FMT_BF_SIGNED,
	input  wire logic [95:0] FMT_DIN,
	output logic             FMT_DONE,
	output logic [95:0]      FMT_DOUT
);
	typedef enum logic [1:0] {S_IDLE, S_CALC, S_FETCH, S_FINAL} ead_state_t;

	function automatic logic is_mem(input ead_mode_t m);
		is_mem = (m == M_MEM_PRE) || (m == M_MEM_POST) ||
			(m == M_PC_MEM_PRE) || (m == M_PC_MEM_POST);
	endfunction

	function automatic logic is_pc(input ead_mode_t m);
		is_pc = (m == M_PC_DISP) || (m == M_PC_IDX8) || (m == M_PC_IDXBD) ||
			(m == M_PC_MEM_PRE) || (m == M_PC_MEM_POST);
	endfunction

	function automatic logic [31:0] line_of(input logic [31:0] a,
		input ead_size_t s);
		line_of = (s == SZ_BLOCK) ? a & ~BLOCK_MASK : a;
	endfunction

	function automatic logic [31:0] sized_imm(input logic [31:0] v,
		input ead_size_t s);
		case (s)
		SZ_BYTE: sized_imm = {24'h0, v[7:0]};
		SZ_WORD: sized_imm = {16'h0, v[15:0]};
		default: sized_imm = v;
		endcase
	endfunction

	ead_state_t  state;
	ead_state_t  next_state;
	ead_mode_t   r_mode;
	ead_size_t   r_size;
	ead_fop_t    r_fop;
	logic [2:0]  r_reg;
	logic [3:0]  r_idx_sel;
	logic [31:0] r_base;
	logic [31:0] r_idx;
	logic [31:0] r_ext;
	logic [31:0] r_od;
	logic [31:0] r_ptr;
	logic        r_idx_long;
	logic        r_ext_long;
	logic        r_bd_en;
	logic        r_od_long;
	logic        r_od_en;
	logic [1:0]  r_scale;
	logic [31:0] dreg [NUM_REGS];
	logic [31:0] areg [NUM_REGS];
	logic        accept;
	logic        ea_fire;
	logic        in_mem;
	logic [31:0] ea_value;
	logic [95:0] fmt_res;

	ead_agen_if ag();

	assign ag.mode     = r_mode;
	assign ag.size     = r_size;
	assign ag.base     = r_base;
	assign ag.idx      = r_idx;
	assign ag.ext      = r_ext;
	assign ag.od       = r_od;
	assign ag.ptr      = r_ptr;
	assign ag.idx_long = r_idx_long;
	assign ag.ext_long = r_ext_long;
	assign ag.bd_en    = r_bd_en;
	assign ag.od_long  = r_od_long;
	assign ag.od_en    = r_od_en;
	assign ag.scale    = r_scale;

	ead_agen u_agen (
		.ag (ag.calc)
	);

	ead_fmt u_fmt (
		.op        (FMT_OP),
		.size      (FMT_SIZE),
		.bf_off    (FMT_BF_OFF),
		.bf_wid    (FMT_BF_WID),
		.bf_signed (FMT_BF_SIGNED),
		.din       (FMT_DIN),
		.dout      (fmt_res)
	);

	assign accept  = REQ_VALID && REQ_READY && (state == S_IDLE);
	assign ea_fire = ((state == S_CALC) && !is_mem(r_mode)) ||
		(state == S_FINAL);
	assign in_mem  = (r_mode != M_DREG) && (r_mode != M_AREG) &&
		(r_mode != M_IMM);

	// block operands are forced onto their 16-byte line
	always_comb begin
		if (!in_mem)
			ea_value = {28'h0, r_mode == M_AREG, r_reg};
		else
			ea_value = line_of(ag.ea, r_size); // [RULE_04]
	end

	always_comb begin
		next_state = state;
		case (state)
		S_IDLE:  if (accept) next_state = S_CALC;
		S_CALC:  next_state = is_mem(r_mode) ? S_FETCH : S_IDLE;
		S_FETCH: if (MEM_RD_VALID) next_state = S_FINAL; // [RULE_15]
		S_FINAL: next_state = S_IDLE;
		default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			state     <= S_IDLE;
			REQ_READY <= 1'b1;
		end else begin
			state     <= next_state;
			REQ_READY <= (next_state == S_IDLE);
		end
	end

	// operands are captured at acceptance so later register writes
	// cannot disturb an address already in flight
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			r_mode     <= M_DREG;
			r_size     <= SZ_LONG;
			r_reg      <= 3'h0;
			r_idx_sel  <= 4'h0;
			r_base     <= RST_REG;
			r_idx      <= RST_REG;
			r_ext      <= RST_REG;
			r_od       <= RST_REG;
			r_idx_long <= 1'b0;
			r_ext_long <= 1'b0;
			r_bd_en    <= 1'b0;
			r_od_long  <= 1'b0;
			r_od_en    <= 1'b0;
			r_scale    <= 2'h0;
		end else if (accept) begin
			r_mode     <= REQ_MODE;
			r_size     <= REQ_SIZE;
			r_reg      <= REQ_REG;
			r_idx_sel  <= REQ_IDX_SEL;
			r_base     <= is_pc(REQ_MODE) ? REQ_PC : areg[REQ_REG]; // [RULE_18]
			r_idx      <= REQ_IDX_SEL[3] ? areg[REQ_IDX_SEL[2:0]] :
				dreg[REQ_IDX_SEL[2:0]]; // [RULE_12]
			r_ext      <= REQ_EXT;
			r_od       <= REQ_OD;
			r_idx_long <= REQ_IDX_LONG;
			r_ext_long <= REQ_EXT_LONG;
			r_bd_en    <= REQ_BD_EN;
			r_od_long  <= REQ_OD_LONG;
			r_od_en    <= REQ_OD_EN;
			r_scale    <= REQ_SCALE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			r_ptr <= RST_REG;
		end else if ((state == S_FETCH) && MEM_RD_VALID) begin
			r_ptr <= MEM_RD_DATA; // [RULE_15]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			MEM_RD_REQ  <= 1'b0;
			MEM_RD_ADDR <= RST_REG;
		end else begin
			MEM_RD_REQ <= (state == S_CALC) && is_mem(r_mode);
			if ((state == S_CALC) && is_mem(r_mode))
				MEM_RD_ADDR <= ag.inner; // [RULE_15] [RULE_19]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			EA_VALID     <= 1'b0;
			EA_ADDR      <= RST_REG;
			EA_IS_REG    <= 1'b0;
			EA_IS_IMM    <= 1'b0;
			EA_IMM       <= RST_REG;
			EA_ALIGN_ERR <= 1'b0;
		end else begin
			EA_VALID <= ea_fire;
			if (ea_fire) begin
				EA_ADDR      <= ea_value;
				EA_IS_REG    <= (r_mode == M_DREG) || (r_mode == M_AREG);
				EA_IS_IMM    <= (r_mode == M_IMM);
				EA_IMM       <= (r_mode == M_IMM) ?
					sized_imm(r_ext, r_size) : 32'h0; // [RULE_16]
				EA_ALIGN_ERR <= in_mem && (r_size == SZ_BLOCK) &&
					((ag.ea & BLOCK_MASK) != 32'h0); // [RULE_04]
			end
		end
	end

	// the address update wins over a same-cycle external write
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				dreg[i] <= RST_REG;
				areg[i] <= RST_REG;
			end
		end else begin
			if (RF_WE && RF_SEL[3])
				areg[RF_SEL[2:0]] <= RF_WDATA;
			if (RF_WE && !RF_SEL[3])
				dreg[RF_SEL[2:0]] <= RF_WDATA;
			if ((state == S_CALC) &&
				((r_mode == M_POSTINC) || (r_mode == M_PREDEC)))
				areg[r_reg] <= ag.reg_next; // [RULE_17] [RULE_20]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			QUAD_DATA <= 64'h0;
		end else begin
			QUAD_DATA <= {dreg[QUAD_HI_SEL], dreg[QUAD_LO_SEL]}; // [RULE_03]
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			FMT_DONE <= 1'b0;
			FMT_DOUT <= 96'h0;
			r_fop    <= F_INT2X;
		end else begin
			FMT_DONE <= FMT_VALID;
			if (FMT_VALID) begin
				FMT_DOUT <= fmt_res; // [RULE_10]
				r_fop    <= FMT_OP;
			end
		end
	end

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);

	sequence s_accept;
		REQ_VALID && REQ_READY;
	endsequence

	sequence s_ptr_back;
		(state == S_FETCH) && MEM_RD_VALID;
	endsequence

	chk_accept_answer: assert property ( // [RULE_17]
		s_accept |-> ##2 (EA_VALID || MEM_RD_REQ))
		else $error("request not answered two cycles after acceptance");

	chk_ptr_final: assert property ( // [RULE_15]
		s_ptr_back |-> ##2 (EA_VALID && EA_ADDR == line_of(ag.ea, r_size) &&
		r_ptr == $past(MEM_RD_DATA, 2)))
		else $error("fetched pointer did not yield the final address");

	chk_block_align: assert property ( // [RULE_04]
		EA_VALID && !EA_IS_REG && !EA_IS_IMM && r_size == SZ_BLOCK
		|-> EA_ADDR[3:0] == 4'h0)
		else $error("block operand address not on a 16-byte line");

	chk_postinc_step: assert property ( // [RULE_20]
		EA_VALID && r_mode == M_POSTINC && !$past(RF_WE)
		|-> areg[r_reg] == r_base + size_bytes(r_size) &&
		EA_ADDR == line_of(r_base, r_size))
		else $error("post-increment step differs from operand size");

	chk_predec_step: assert property ( // [RULE_20]
		EA_VALID && r_mode == M_PREDEC && !$past(RF_WE)
		|-> areg[r_reg] == r_base - size_bytes(r_size) &&
		EA_ADDR == line_of(areg[r_reg], r_size))
		else $error("predecrement address or register wrong");

	chk_disp_sext: assert property ( // [RULE_11]
		EA_VALID && (r_mode == M_DISP16 || r_mode == M_PC_DISP)
		|-> EA_ADDR == line_of(r_base + sext16(r_ext[15:0]), r_size))
		else $error("word displacement not sign extended");

	chk_abs_short: assert property ( // [RULE_21]
		EA_VALID && r_mode == M_ABS_W
		|-> EA_ADDR == line_of(sext16(r_ext[15:0]), r_size))
		else $error("absolute short address not sign extended");

	chk_imm_width: assert property ( // [RULE_16]
		EA_VALID && EA_IS_IMM && r_size == SZ_BYTE |-> EA_IMM[31:8] == 24'h0)
		else $error("byte immediate wider than eight bits");

	chk_ext_pad: assert property ( // [RULE_08]
		FMT_DONE && r_fop == F_X2MEM |-> FMT_DOUT[79:64] == 16'h0 &&
		FMT_DOUT[95:80] == $past(FMT_DIN[79:64]))
		else $error("extended memory image pad word not clear");
endmodule

// *** pkg/ead_agen_if.sv ***
// ead_agen_if: latched request fields to the address adder and its results
// assumes the requester holds all inputs stable while it samples results
`timescale 1ns/100ps
interface ead_agen_if;
	import ead_pkg::*;
	ead_mode_t   mode;
	ead_size_t   size;
	logic [31:0] base, idx, ext, od, ptr;
	logic        idx_long, ext_long, bd_en, od_long, od_en;
	logic [1:0]  scale;
	logic [31:0] inner, ea, reg_next;

	modport req (output mode, size, base, idx, ext, od, ptr, idx_long,
		ext_long, bd_en, od_long, od_en, scale, input inner, ea, reg_next);
	modport calc (input mode, size, base, idx, ext, od, ptr, idx_long,
		ext_long, bd_en, od_long, od_en, scale, output inner, ea, reg_next);
endinterface

// *** pkg/ead_pkg.sv ***
// ead_pkg: addressing modes, operand sizes, format codes and constants
// assumes a 32-bit byte-addressed core datapath
package ead_pkg;
	typedef enum logic [4:0] {
		M_DREG, M_AREG, M_IND, M_POSTINC, M_PREDEC, M_DISP16,
		M_IDX8, M_IDXBD, M_MEM_POST, M_MEM_PRE, M_PC_DISP,
		M_PC_IDX8, M_PC_IDXBD, M_PC_MEM_POST, M_PC_MEM_PRE,
		M_ABS_W, M_ABS_L, M_IMM
	} ead_mode_t;

	typedef enum logic [2:0] {
		SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD, SZ_BLOCK, SZ_SINGLE,
		SZ_DOUBLE, SZ_EXT
	} ead_size_t;

	typedef enum logic [2:0] {
		F_INT2X, F_SGL2X, F_DBL2X, F_X2MEM, F_BCD_PACK, F_BCD_UNPK,
		F_BF_EXT
	} ead_fop_t;

	localparam int          NUM_REGS   = 8;
	localparam int          S_MAN_W    = 23;
	localparam int          D_MAN_W    = 52;
	localparam int          X_W        = 80;
	localparam int          X_MAN_W    = 64;
	localparam int          X_PAD_W    = 16;
	localparam int          X_MEM_W    = 96;
	localparam logic [14:0] X_BIAS     = 15'h3fff;
	localparam logic [14:0] X_EXP_MAX  = 15'h7fff;
	localparam logic [14:0] S_BIAS     = 15'h007f;
	localparam logic [14:0] D_BIAS     = 15'h03ff;
	localparam logic [7:0]  S_EXP_MAX  = 8'hff;
	localparam logic [10:0] D_EXP_MAX  = 11'h7ff;
	localparam logic [31:0] BLOCK_MASK = 32'h0000000f;
	localparam logic [31:0] RST_REG    = 32'h00000000;

	function automatic logic [31:0] sext8(input logic [7:0] v);
		sext8 = {{24{v[7]}}, v};
	endfunction

	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] size_bytes(input ead_size_t s);
		case (s)
		SZ_BYTE:   size_bytes = 32'h1;
		SZ_WORD:   size_bytes = 32'h2;
		SZ_QUAD:   size_bytes = 32'h8;
		SZ_BLOCK:  size_bytes = 32'h10;
		SZ_DOUBLE: size_bytes = 32'h8;
		SZ_EXT:    size_bytes = 32'hc;
		default:   size_bytes = 32'h4;
		endcase
	endfunction
endpackage

// *** verif/ead_top_test.sv ***
// ead_top_test: random self-checking bench for ead_top
// assumes a bench-side copy of the register file predicts every address
`timescale 1ns/100ps
module ead_top_test
	import ead_pkg::*;
;
	logic        CLK_SYS = 1'b0, NRST = 1'b0, REQ_VALID = 1'b0;
	logic        REQ_IDX_LONG = 1'b0, REQ_EXT_LONG = 1'b0, REQ_BD_EN = 1'b0;
	logic        REQ_OD_LONG = 1'b0, REQ_OD_EN = 1'b0, RF_WE = 1'b0;
	logic        MEM_RD_VALID = 1'b0, FMT_VALID = 1'b0, FMT_BF_SIGNED = 1'b0;
	ead_mode_t   REQ_MODE = M_IND;
	ead_size_t   REQ_SIZE = SZ_LONG, FMT_SIZE = SZ_LONG;
	ead_fop_t    FMT_OP = F_X2MEM;
	logic [2:0]  REQ_REG = 3'h0, QUAD_HI_SEL = 3'h0, QUAD_LO_SEL = 3'h0;
	logic [3:0]  REQ_IDX_SEL = 4'h0, RF_SEL = 4'h0;
	logic [1:0]  REQ_SCALE = 2'h0;
	logic [4:0]  FMT_BF_OFF = 5'h0, FMT_BF_WID = 5'h0;
	logic [31:0] REQ_EXT = 32'h0, REQ_OD = 32'h0, REQ_PC = 32'h0;
	logic [31:0] MEM_RD_DATA = 32'h0, RF_WDATA = 32'h0;
	logic [95:0] FMT_DIN = 96'h0;
	logic        REQ_READY, EA_VALID, EA_IS_REG, EA_IS_IMM, EA_ALIGN_ERR;
	logic        MEM_RD_REQ, FMT_DONE;
	logic [31:0] EA_ADDR, EA_IMM, MEM_RD_ADDR;
	logic [63:0] QUAD_DATA;
	logic [95:0] FMT_DOUT;
	logic [31:0] dr [8], ar [8];
	integer      seed = 41163, error_cnt = 0, n_compared = 0;

	ead_top dut_u (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ_VALID(REQ_VALID),
		.REQ_MODE(REQ_MODE), .REQ_SIZE(REQ_SIZE), .REQ_REG(REQ_REG),
		.REQ_IDX_SEL(REQ_IDX_SEL), .REQ_IDX_LONG(REQ_IDX_LONG),
		.REQ_SCALE(REQ_SCALE), .REQ_EXT(REQ_EXT), .REQ_EXT_LONG(REQ_EXT_LONG),
		.REQ_BD_EN(REQ_BD_EN), .REQ_OD(REQ_OD), .REQ_OD_LONG(REQ_OD_LONG),
		.REQ_OD_EN(REQ_OD_EN), .REQ_PC(REQ_PC), .REQ_READY(REQ_READY),
		.EA_VALID(EA_VALID), .EA_ADDR(EA_ADDR), .EA_IS_REG(EA_IS_REG),
		.EA_IS_IMM(EA_IS_IMM), .EA_IMM(EA_IMM), .EA_ALIGN_ERR(EA_ALIGN_ERR),
		.MEM_RD_REQ(MEM_RD_REQ), .MEM_RD_ADDR(MEM_RD_ADDR),
		.MEM_RD_VALID(MEM_RD_VALID), .MEM_RD_DATA(MEM_RD_DATA),
		.RF_WE(RF_WE), .RF_SEL(RF_SEL), .RF_WDATA(RF_WDATA),
		.QUAD_HI_SEL(QUAD_HI_SEL), .QUAD_LO_SEL(QUAD_LO_SEL),
		.QUAD_DATA(QUAD_DATA), .FMT_VALID(FMT_VALID), .FMT_OP(FMT_OP),
		.FMT_SIZE(FMT_SIZE), .FMT_BF_OFF(FMT_BF_OFF), .FMT_BF_WID(FMT_BF_WID),
		.FMT_BF_SIGNED(FMT_BF_SIGNED), .FMT_DIN(FMT_DIN),
		.FMT_DONE(FMT_DONE), .FMT_DOUT(FMT_DOUT));

	initial begin
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction

	function automatic logic [31:0] sx16(input logic [31:0] v);
		return {{16{v[15]}}, v[15:0]};
	endfunction

	function automatic logic [31:0] nbytes(input ead_size_t s);
		case (s)
		SZ_BYTE: return 32'h1;
		SZ_WORD: return 32'h2;
		SZ_QUAD, SZ_DOUBLE: return 32'h8;
		SZ_BLOCK: return 32'h10;
		SZ_EXT: return 32'hc;
		default: return 32'h4;
		endcase
	endfunction

	task automatic check(input logic [95:0] got, input logic [95:0] want);
		n_compared++;
		if (got !== want) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic end_sim;
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// fields were set at an earlier edge, so they are stable here
	task automatic do_req;
		logic [31:0] base, idx, bd, od, inner, ea, ptr, sz;
		logic        ind, pre, mem, err;
		int          n;
		REQ_VALID <= 1'b1;
		do @(posedge CLK_SYS); while (REQ_READY !== 1'b1);
		REQ_VALID <= 1'b0;
		mem = !(REQ_MODE inside {M_DREG, M_AREG, M_IMM});
		base = (REQ_MODE inside {[M_PC_DISP:M_PC_MEM_PRE]}) ? REQ_PC
			: ar[REQ_REG];
		idx = REQ_IDX_SEL[3] ? ar[REQ_IDX_SEL[2:0]] : dr[REQ_IDX_SEL[2:0]];
		idx = (REQ_IDX_LONG ? idx : sx16(idx)) << REQ_SCALE;
		bd = !REQ_BD_EN ? 32'h0 : REQ_EXT_LONG ? REQ_EXT : sx16(REQ_EXT);
		od = !REQ_OD_EN ? 32'h0 : REQ_OD_LONG ? REQ_OD : sx16(REQ_OD);
		sz = nbytes(REQ_SIZE);
		pre = REQ_MODE inside {M_MEM_PRE, M_PC_MEM_PRE};
		ind = pre || REQ_MODE inside {M_MEM_POST, M_PC_MEM_POST};
		inner = base + bd + (pre ? idx : 32'h0);
		case (REQ_MODE)
		M_DREG, M_AREG, M_IMM: ea = {28'h0, REQ_MODE == M_AREG, REQ_REG};
		M_IND, M_POSTINC: ea = base;
		M_PREDEC: ea = base - sz;
		M_DISP16, M_PC_DISP: ea = base + sx16(REQ_EXT);
		M_IDX8, M_PC_IDX8: ea = base + {{24{REQ_EXT[7]}}, REQ_EXT[7:0]} + idx;
		M_IDXBD, M_PC_IDXBD: ea = inner + idx;
		M_ABS_W: ea = sx16(REQ_EXT);
		M_ABS_L: ea = REQ_EXT;
		default: ea = 32'h0;
		endcase
		if (REQ_MODE == M_POSTINC)
			ar[REQ_REG] = base + sz;
		if (REQ_MODE == M_PREDEC)
			ar[REQ_REG] = ea;
		if (ind) begin
			n = 0;
			do begin @(posedge CLK_SYS); n++; end
			while (MEM_RD_REQ !== 1'b1 && n < 9);
			check(n, 2);
			check(MEM_RD_ADDR, inner);
			ptr = rnd();
			repeat (rnd() % 3) @(posedge CLK_SYS);
			MEM_RD_VALID <= 1'b1;
			MEM_RD_DATA <= ptr;
			@(posedge CLK_SYS);
			MEM_RD_VALID <= 1'b0;
			MEM_RD_DATA <= ~ptr;
			ea = ptr + od + (pre ? 32'h0 : idx);
		end
		n = 0;
		do begin @(posedge CLK_SYS); n++; end
		while (EA_VALID !== 1'b1 && n < 9);
		err = mem && REQ_SIZE == SZ_BLOCK && ea[3:0] != 4'h0;
		if (mem && REQ_SIZE == SZ_BLOCK)
			ea[3:0] = 4'h0;
		check(n, 2);
		check(EA_ADDR, ea);
		check(EA_ALIGN_ERR, err);
		check(EA_IS_REG, REQ_MODE inside {M_DREG, M_AREG});
		check(EA_IS_IMM, REQ_MODE == M_IMM);
		if (REQ_MODE == M_IMM)
			check(EA_IMM, REQ_EXT & (32'hffffffff >> (32 - 8 * sz)));
	endtask

	task automatic do_fmt;
		logic [95:0] w, m;
		logic [63:0] v;
		logic [31:0] f;
		logic        s;
		int          p;
		FMT_VALID <= 1'b1;
		@(posedge CLK_SYS);
		FMT_VALID <= 1'b0;
		m = {16'h0, {80{1'b1}}};
		w = 96'h0;
		s = 1'b0;
		case (FMT_OP)
		F_X2MEM: begin
			w = {FMT_DIN[79:64], 16'h0, FMT_DIN[63:0]};
			m = '1;
		end
		F_BF_EXT: begin
			v = FMT_DIN[63:0] >> FMT_BF_OFF;
			p = (FMT_BF_WID == 5'h0) ? 32 : FMT_BF_WID;
			f = v[31:0] & (32'hffffffff >> (32 - p));
			if (FMT_BF_SIGNED && f[p-1])
				f = f | ~(32'hffffffff >> (32 - p));
			w = {64'h0, f};
			m = 96'hffffffff;
		end
		F_BCD_PACK: begin
			w = {80'h0, FMT_DIN[27:24], FMT_DIN[19:16], FMT_DIN[11:8],
				FMT_DIN[3:0]};
			m = 96'hffff;
		end
		F_BCD_UNPK: begin
			w = {64'h0, 4'h0, FMT_DIN[15:12], 4'h0, FMT_DIN[11:8], 4'h0,
				FMT_DIN[7:4], 4'h0, FMT_DIN[3:0]};
			m = 96'hffffffff;
		end
		F_INT2X: begin
			case (FMT_SIZE)
			SZ_BYTE: v = {{56{FMT_DIN[7]}}, FMT_DIN[7:0]};
			SZ_WORD: v = {{48{FMT_DIN[15]}}, FMT_DIN[15:0]};
			default: v = {{32{FMT_DIN[31]}}, FMT_DIN[31:0]};
			endcase
			s = v[63];
			if (s)
				v = -v;
			p = 63;
			while (p > 0 && !v[p])
				p--;
			if (v != 64'h0)
				w[79:0] = {s, X_BIAS + 15'(p), v << (63 - p)};
		end
		F_SGL2X: begin
			if (FMT_DIN[30:23] == S_EXP_MAX)
				w[79:0] = {FMT_DIN[31], X_EXP_MAX, 1'b1,
					FMT_DIN[22:0], 40'h0};
			else if (FMT_DIN[30:23] != 8'h0)
				w[79:0] = {FMT_DIN[31], 15'(FMT_DIN[30:23]) - S_BIAS + X_BIAS,
					1'b1, FMT_DIN[22:0], 40'h0};
			else
				w[79] = FMT_DIN[31];
		end
		default: begin
			if (FMT_DIN[62:52] == D_EXP_MAX)
				w[79:0] = {FMT_DIN[63], X_EXP_MAX, 1'b1,
					FMT_DIN[51:0], 11'h0};
			else if (FMT_DIN[62:52] != 11'h0)
				w[79:0] = {FMT_DIN[63], 15'(FMT_DIN[62:52]) - D_BIAS + X_BIAS,
					1'b1, FMT_DIN[51:0], 11'h0};
			else
				w[79] = FMT_DIN[63];
		end
		endcase
		@(posedge CLK_SYS);
		check(FMT_DONE, 1'b1);
		check(FMT_DOUT & m, w & m);
	endtask

	initial begin
		#500000;
		error_cnt++;
		end_sim;
	end

	initial begin
		int          k;
		logic [31:0] d;
		repeat (6) @(posedge CLK_SYS);
		NRST <= 1'b1;
		@(posedge CLK_SYS);
		check({REQ_READY, EA_VALID, MEM_RD_REQ, FMT_DONE}, 4'h8);
		// load all sixteen registers back to back with random values
		for (k = 0; k < 16; k++) begin
			d = rnd();
			RF_WE <= 1'b1;
			RF_SEL <= k[3:0];
			RF_WDATA <= d;
			@(posedge CLK_SYS);
			if (k < 8) dr[k] = d; else ar[k - 8] = d;
		end
		RF_WE <= 1'b0;
		for (k = 0; k < 8; k++) begin
			QUAD_HI_SEL <= 3'(rnd());
			QUAD_LO_SEL <= k[2:0];
			repeat (2) @(posedge CLK_SYS);
			check(QUAD_DATA, {dr[QUAD_HI_SEL], dr[QUAD_LO_SEL]});
		end
		// first pass of each mode uses negative short and word fields
		for (k = 0; k < 180; k++) begin
			d = rnd();
			REQ_MODE <= ead_mode_t'(k % 18);
			REQ_SIZE <= (k % 18 == 17) ? ead_size_t'(d[1:0] % 3)
				: ead_size_t'(d[2:0]);
			REQ_REG <= d[5:3];
			REQ_IDX_SEL <= d[9:6];
			REQ_IDX_LONG <= k < 18 ? 1'b0 : d[10];
			REQ_SCALE <= k < 18 ? 2'h3 : d[12:11];
			REQ_EXT_LONG <= k < 18 ? 1'b0 : d[13];
			REQ_BD_EN <= k < 18 ? 1'b1 : d[14];
			REQ_OD_LONG <= k < 18 ? 1'b0 : d[15];
			REQ_OD_EN <= k < 18 ? 1'b1 : d[16];
			REQ_EXT <= k < 18 ? 32'h00008080 : rnd();
			REQ_OD <= k < 18 ? 32'h00008000 : rnd();
			REQ_PC <= rnd();
			@(posedge CLK_SYS);
			do_req;
		end
		for (k = 0; k < 70; k++) begin
			d = rnd();
			FMT_OP <= ead_fop_t'(k % 7);
			FMT_SIZE <= ead_size_t'(d[1:0] % 3);
			FMT_BF_OFF <= d[6:2];
			FMT_BF_WID <= k < 7 ? 5'h0 : d[11:7];
			FMT_BF_SIGNED <= d[12];
			// second pass drives the largest single and double exponents
			FMT_DIN <= k < 7 ? 96'h80000000 : k < 14 ? 96'h7ff00000ff800000
				: {rnd(), rnd(), rnd()};
			@(posedge CLK_SYS);
			do_fmt;
		end
		end_sim;
	end
endmodule
